// ### dv/host_model.sv
// host model driving the command port of the rail configuration block
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_data_i,
  input wire logic rsp_unsup_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_data_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'hff;
    cmd_data_o = 16'hffff;
  end
  // one command a call; page writes steer later commands
  task automatic xfer(input logic w, input logic [7:0] c,
      input logic [15:0] d, output logic [15:0] q, output logic u);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = w;
    cmd_code_o = c;
    cmd_data_o = d;
    @(negedge clk_i);
    // answer stands only in the cycle after the taking edge
    q = rsp_valid_i ? rsp_data_i : ~rsp_data_i;
    u = rsp_unsup_i;
    cmd_valid_o = 1'b0;
    cmd_write_o = ~w;
    cmd_code_o = ~c;
    cmd_data_o = ~d;
  endtask
endmodule
`default_nettype wire

// ### dv/rail_fault_checker_asserts.sv
// port assertions for the rail fault configuration block
`timescale 1ns/100ps
`default_nettype none
`include "rail_fault_params.svh"
module rail_fault_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic [1:0] cur_sample_valid_i,
  input wire logic [1:0] avg_oc_fault_i,
  input wire logic [1:0] avg_uc_fault_i,
  input wire logic [1:0] output_on_i,
  input wire logic [1:0] ramping_i,
  input wire logic rsp_valid_o,
  input wire logic [15:0] rsp_data_o,
  input wire logic rsp_unsup_o,
  input wire logic [1:0][4:0] fault_status_o,
  input wire logic alert_o,
  input wire logic [1:0][1:0] phase_pulse_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic bad_page = cmd_valid_i && cmd_write_i &&
    cmd_code_i == `CMD_PAGE &&
    !(cmd_data_i[7:0] inside {`PAGE_CH0, `PAGE_CH1, `PAGE_BOTH});
  wire logic oc_quiet = !avg_oc_fault_i[0] && !cur_sample_valid_i[0];
  sequence s_read(logic [7:0] c);
    cmd_valid_i && !cmd_write_i && cmd_code_i == c;
  endsequence
  sequence s_clear_quiet;
    oc_quiet ##1 oc_quiet && cmd_valid_i &&
      cmd_code_i == `CMD_CLEAR_FAULTS ##1 oc_quiet;
  endsequence
  property p_rsp_follow;
    cmd_valid_i |=> rsp_valid_o;
  endproperty
  property p_phase_rsv;
    s_read(`CMD_PHASE) |=> rsp_data_o[15:4] == 12'h002;
  endproperty
  property p_action_top;
    s_read(`CMD_VOV_ACT) or s_read(`CMD_VUV_ACT) |=>
      rsp_data_o[15:6] == 10'h002;
  endproperty
  property p_page_bad;
    bad_page |=> rsp_unsup_o;
  endproperty
  property p_alert_or;
    alert_o == (|fault_status_o);
  endproperty
  property p_oc_share;
    output_on_i[0] && avg_oc_fault_i[0] |-> ##2 fault_status_o[0][`FB_OC];
  endproperty
  property p_uc_share;
    output_on_i[0] && avg_uc_fault_i[0] |-> ##2 fault_status_o[0][`FB_UC];
  endproperty
  property p_uv_mask;
    $rose(fault_status_o[0][`FB_UV]) |->
      $past(output_on_i[0], 2) && !$past(ramping_i[0], 2);
  endproperty
  property p_clear;
    s_clear_quiet |=> !fault_status_o[0][`FB_OC];
  endproperty
  property p_split;
    phase_pulse_o[0][0] |-> !phase_pulse_o[0][1];
  endproperty
  a_rsp_follow: assert property (p_rsp_follow)
    else $error("no answer after command");
  a_phase_rsv: assert property (p_phase_rsv)
    else $error("phase reserved bits wrong");
  a_action_top: assert property (p_action_top)
    else $error("action top bits wrong");
  a_page_bad: assert property (p_page_bad)
    else $error("bad page not refused");
  a_alert_or: assert property (p_alert_or)
    else $error("alert differs from status");
  a_oc_share: assert property (p_oc_share)
    else $error("average overcurrent bit missing");
  a_uc_share: assert property (p_uc_share)
    else $error("average undercurrent bit missing");
  a_uv_mask: assert property (p_uv_mask)
    else $error("undervoltage not masked");
  a_clear: assert property (p_clear)
    else $error("clear faults left a bit");
  a_split: assert property (p_split)
    else $error("both phases pulsed together");
endmodule
bind rail_fault_limit_response_config rail_fault_checker rail_fault_checker_i (
  .clk_i, .rstn_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_data_i,
  .cur_sample_valid_i, .avg_oc_fault_i, .avg_uc_fault_i, .output_on_i,
  .ramping_i, .rsp_valid_o, .rsp_data_o, .rsp_unsup_o, .fault_status_o,
  .alert_o, .phase_pulse_o);
`default_nettype wire

// ### dv/rail_fault_limit_response_config_tb_top.sv
// self-checking bench for the rail fault configuration block
`timescale 1ns/100ps
`default_nettype none
`include "rail_fault_params.svh"
module rail_fault_limit_response_config_tb_top;
  logic clk_i, rstn_i, sync_i, cmd_valid_i, cmd_write_i, u;
  logic rsp_valid_o, rsp_unsup_o, alert_o;
  logic [7:0] cmd_code_i;
  logic [15:0] cmd_data_i, rsp_data_o, q, d;
  logic [1:0][15:0] vout_i, cur_sample_i, temp_i, ot_warn_thr_i;
  logic [1:0][7:0] other_fault_action_i;
  logic [1:0] cur_sample_valid_i, blank_done_i, avg_oc_fault_i;
  logic [1:0] avg_uc_fault_i, output_on_i, ramping_i, pgood_o, output_off_o;
  logic [1:0][4:0] fault_status_o;
  logic [1:0][1:0] phase_pulse_o;
  int n_mismatch = 0, comparisons = 0, seed = 3, cyc = 0, n, t0, t1, t2, t3;
  logic [7:0] codes [13] = '{8'h37, 8'h38, 8'h39, 8'h40, 8'h41, 8'h42,
    8'h43, 8'h44, 8'h45, 8'h46, 8'h4a, 8'h4b, 8'h4f};
  logic [7:0] mcode [3] = '{8'h37, 8'h41, 8'h45};
  logic [7:0] hact [3] = '{8'h80, 8'h88, 8'hb0};
  logic [15:0] pv [5] = '{16'h2000, 16'h3001, 16'h0fff, 16'h3000, 16'h1000};
  logic [15:0] tv [3] = '{16'h0780, 16'h06e0, 16'h0640};
  logic [1:0] um [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  rail_fault_limit_response_config #(.RETRY_UNIT_CYC(10))
      rail_fault_limit_response_config_i (
    .clk_i, .rstn_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_data_i,
    .sync_i, .vout_i, .cur_sample_i, .cur_sample_valid_i, .blank_done_i,
    .avg_oc_fault_i, .avg_uc_fault_i, .temp_i, .ot_warn_thr_i,
    .other_fault_action_i, .output_on_i, .ramping_i, .rsp_valid_o,
    .rsp_data_o, .rsp_unsup_o, .pgood_o, .output_off_o, .fault_status_o,
    .alert_o, .phase_pulse_o);
  host_model host_model_i (.clk_i, .rsp_valid_i(rsp_valid_o),
    .rsp_data_i(rsp_data_o), .rsp_unsup_i(rsp_unsup_o),
    .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
    .cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  // shared sync, one pulse every 64 cycles
  initial begin
    sync_i = 1'b0;
    forever begin
      repeat (63) @(negedge clk_i);
      sync_i = 1'b1;
      @(negedge clk_i);
      sync_i = 1'b0;
    end
  end
  task automatic final_report();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clk_i);
    n_mismatch++;
    final_report();
  end
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: bit %b expected %b", $time, g, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    host_model_i.xfer(1'b1, c, v, q, u);
  endtask
  task automatic rd(input logic [7:0] c);
    host_model_i.xfer(1'b0, c, 16'h0000, q, u);
  endtask
  function automatic logic [15:0] exp_rst(input logic [7:0] c, input logic ch);
    case (c)
      8'h37: exp_rst = ch ? 16'h0022 : 16'h0021;
      8'h38: exp_rst = ch ? 16'hb2d7 : 16'hb2c3;
      8'h39: exp_rst = ch ? 16'hbddc : 16'hb529;
      8'h40, 8'h42: exp_rst = `RST_VOV_FAULT;
      8'h41, 8'h45: exp_rst = 16'h0080;
      8'h46: exp_rst = 16'he320;
      8'h4b: exp_rst = 16'he4e0;
      8'h4f: exp_rst = 16'heb98;
      default: exp_rst = `RST_VUV_WARN;
    endcase
  endfunction
  function automatic logic [15:0] exp_mask(input logic [7:0] c,
      input logic [15:0] v);
    if (c == 8'h37) return 16'h0020 | (v & 16'h000f);
    return 16'h0080 | (v & 16'h003f);
  endfunction
  // pulse an average overcurrent, count cycles held off
  task automatic fault_run(input logic [7:0] act, output int k);
    int w;
    w = 0;
    other_fault_action_i[0] = act;
    avg_oc_fault_i[0] = 1'b1;
    tick(1);
    avg_oc_fault_i[0] = 1'b0;
    k = 0;
    while (output_off_o[0] !== 1'b1 && w < 5) begin
      tick(1);
      w++;
    end
    while (output_off_o[0] === 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
  endtask
  task automatic sample(input logic [15:0] s, input logic b, input int f,
      input logic e);
    wr(`CMD_CLEAR_FAULTS, 16'h0000);
    cur_sample_i[0] = s;
    cur_sample_valid_i[0] = 1'b1;
    blank_done_i[0] = b;
    tick(1);
    cur_sample_valid_i[0] = 1'b0;
    tick(3);
    chk_bit(fault_status_o[0][f], e);
  endtask
  task automatic wait_pulse(input int c, input int p, output int t);
    int k;
    k = 0;
    while (phase_pulse_o[c][p] !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    t = cyc;
    tick(1);
  endtask
  initial begin
    rstn_i = 1'b0;
    {cur_sample_valid_i, blank_done_i, avg_oc_fault_i} = '0;
    {avg_uc_fault_i, output_on_i, ramping_i, cur_sample_i, temp_i} = '0;
    vout_i = {2{16'h2000}};
    ot_warn_thr_i = {2{16'heb48}};
    other_fault_action_i = {2{8'h80}};
    repeat (16) @(posedge clk_i);
    tick(1);
    rstn_i = 1'b1;
    for (int ch = 0; ch < 2; ch++) begin
      wr(`CMD_PAGE, 16'(ch));
      foreach (codes[i]) begin
        rd(codes[i]);
        chk_word(q, exp_rst(codes[i], ch[0]));
      end
    end
    for (int i = 0; i < 9; i++) begin
      d = (i < 3) ? 16'h0000 : (i < 6) ? 16'hffff : 16'($random(seed));
      wr(mcode[i % 3], d);
      rd(mcode[i % 3]);
      chk_word(q, exp_mask(mcode[i % 3], d));
    end
    wr(`CMD_PAGE, 16'h0002);
    chk_bit(u, 1'b1);
    wr(`CMD_PAGE, 16'h00ff);
    wr(`CMD_PHASE, 16'h0004);
    wr(`CMD_PAGE, 16'h0001);
    rd(`CMD_PHASE);
    chk_word(q, 16'h0024);
    wr(`CMD_PHASE, 16'h0008);
    wr(`CMD_PAGE, 16'h0000);
    tick(200);
    wait_pulse(0, 0, t0);
    wait_pulse(1, 0, t1);
    wait_pulse(0, 1, t2);
    wait_pulse(0, 0, t3);
    chk_word(16'(t1 - t0), 16'h0010);
    chk_word(16'(t2 - t0), 16'h0020);
    chk_word(16'(t3 - t0), 16'h0040);
    output_on_i[0] = 1'b1;
    tick(3);
    for (int k = 0; k < 8; k++) begin
      fault_run(8'hb8 | 8'(k), n);
      chk_word(16'(n), 16'(10 * (k + 1)));
      tick(3);
    end
    foreach (hact[i]) begin
      output_on_i[0] = 1'b1;
      tick(2);
      fault_run(hact[i], n);
      chk_word(16'(n), 16'h00c8);
      output_on_i[0] = 1'b0;
      tick(2);
      chk_bit(output_off_o[0], 1'b0);
    end
    output_on_i[0] = 1'b1;
    wr(`CMD_OC_FAULT, 16'h003c);
    wr(`CMD_UC_FAULT, 16'h07c4);
    sample(16'h0370, 1'b0, `FB_OC, 1'b0);
    sample(16'h0370, 1'b1, `FB_OC, 1'b1);
    sample(16'hfc90, 1'b1, `FB_UC, 1'b1);
    wr(`CMD_VOV_WARN, 16'h3000);
    wr(`CMD_VUV_WARN, 16'h1000);
    for (int i = 0; i < 8; i++) begin
      d = (i < 5) ? pv[i] : 16'($random(seed));
      vout_i[0] = d;
      tick(2);
      chk_bit(pgood_o[0], d <= 16'h3000 && d >= 16'h1000);
    end
    vout_i[0] = 16'h0800;
    wr(`CMD_VUV_FAULT, 16'h1000);
    foreach (um[i]) begin
      {output_on_i[0], ramping_i[0]} = um[i];
      wr(`CMD_CLEAR_FAULTS, 16'h0000);
      tick(3);
      chk_bit(fault_status_o[0][`FB_UV], um[i] == 2'b10);
    end
    vout_i[0] = 16'h2000;
    output_on_i[0] = 1'b0;
    foreach (tv[i]) begin
      temp_i[0] = tv[i];
      tick(2);
      wr(`CMD_CLEAR_FAULTS, 16'h0000);
      tick(1);
      chk_bit(fault_status_o[0][`FB_OT], i < 2);
    end
    chk_bit(alert_o, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire

// ### src/rail_fault_limit_response_config.sv
// per-channel fault limits, fault responses and phase placement of a rail
`timescale 1ns/100ps
`default_nettype none
`include "rail_fault_params.svh"

module rail_fault_limit_response_config #(
  parameter int RETRY_UNIT_CYC = `RETRY_UNIT_MS * 1000 * `CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic sync_i,
  input wire logic [1:0][15:0] vout_i,
  input wire logic [1:0][15:0] cur_sample_i,
  input wire logic [1:0] cur_sample_valid_i,
  input wire logic [1:0] blank_done_i,
  input wire logic [1:0] avg_oc_fault_i,
  input wire logic [1:0] avg_uc_fault_i,
  input wire logic [1:0][15:0] temp_i,
  input wire logic [1:0][15:0] ot_warn_thr_i,
  input wire logic [1:0][7:0] other_fault_action_i,
  input wire logic [1:0] output_on_i,
  input wire logic [1:0] ramping_i,
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  output logic rsp_unsup_o,
  output logic [1:0] pgood_o,
  output logic [1:0] output_off_o,
  output logic [1:0][4:0] fault_status_o,
  output logic alert_o,
  output logic [1:0][1:0] phase_pulse_o
);

  // l11 word to signed sixteenths
  function automatic logic signed [31:0] l11_q4(input logic [15:0] w);
    logic signed [31:0] m;
    logic signed [31:0] s;
    logic signed [31:0] ns;
    m = 32'(signed'(w[10:0]));
    s = 32'(signed'(w[15:11])) + `Q4_SHIFT;
    ns = -s;
    if (s >= 0) begin
      l11_q4 = m <<< s[4:0];
    end else begin
      l11_q4 = m >>> ns[4:0];
    end
  endfunction

  function automatic logic signed [31:0] clamp(
    input logic signed [31:0] v,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction

  // command decode
  logic [7:0] page_ff;
  logic [3:0] cmd_ix;
  logic cmd_known;
  always_comb begin
    cmd_known = 1'b1;
    case (cmd_code_i)
      `CMD_PHASE: cmd_ix = `IX_PHASE;
      `CMD_GAIN_CAL: cmd_ix = `IX_GAIN_CAL;
      `CMD_OFFS_CAL: cmd_ix = `IX_OFFS_CAL;
      `CMD_VOV_FAULT: cmd_ix = `IX_VOV_FAULT;
      `CMD_VOV_ACT: cmd_ix = `IX_VOV_ACT;
      `CMD_VOV_WARN: cmd_ix = `IX_VOV_WARN;
      `CMD_VUV_WARN: cmd_ix = `IX_VUV_WARN;
      `CMD_VUV_FAULT: cmd_ix = `IX_VUV_FAULT;
      `CMD_VUV_ACT: cmd_ix = `IX_VUV_ACT;
      `CMD_OC_FAULT: cmd_ix = `IX_OC_FAULT;
      `CMD_OC_WARN: cmd_ix = `IX_OC_WARN;
      `CMD_UC_FAULT: cmd_ix = `IX_UC_FAULT;
      `CMD_OT_FAULT: cmd_ix = `IX_OT_FAULT;
      default: begin
        cmd_ix = `IX_PHASE;
        cmd_known = 1'b0;
      end
    endcase
  end

  wire is_page = (cmd_code_i == `CMD_PAGE);
  wire is_clear = (cmd_code_i == `CMD_CLEAR_FAULTS);
  wire cfg_wr = cmd_valid_i & cmd_write_i & cmd_known;
  wire clear_faults = cmd_valid_i & is_clear;
  wire page_ok = (cmd_data_i[7:0] == `PAGE_CH0) |
                 (cmd_data_i[7:0] == `PAGE_CH1) |
                 (cmd_data_i[7:0] == `PAGE_BOTH);
  wire page_wr = cmd_valid_i & cmd_write_i & is_page & page_ok;
  wire [1:0] ch_sel = (page_ff == `PAGE_BOTH) ? 2'b11 :
                      ((page_ff == `PAGE_CH1) ? 2'b10 : 2'b01);
  wire rd_ch = (page_ff == `PAGE_CH1);

  // reserved bits forced on phase and action word writes
  logic [15:0] wr_word;
  always_comb begin
    case (cmd_ix)
      `IX_PHASE: wr_word = `PHASE_FIXED | (cmd_data_i & `PHASE_MASK);
      `IX_VOV_ACT,
      `IX_VUV_ACT: wr_word = `ACTION_FIXED | (cmd_data_i & `ACTION_MASK);
      default: wr_word = cmd_data_i;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      page_ff <= `PAGE_CH0;
    end else if (page_wr) begin
      page_ff <= cmd_data_i[7:0];
    end
  end

  // sync pin: two flops, then edge detect on the second
  logic sync_meta_ff;
  logic sync_s_ff;
  logic sync_d_ff;
  logic [19:0] per_cnt_ff;
  logic [19:0] period_ff;
  wire sync_edge = sync_s_ff & ~sync_d_ff;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_meta_ff <= 1'b0;
      sync_s_ff <= 1'b0;
      sync_d_ff <= 1'b0;
      per_cnt_ff <= 20'h0_0000;
      period_ff <= 20'h0_0000;
    end else begin
      sync_meta_ff <= sync_i;
      sync_s_ff <= sync_meta_ff;
      sync_d_ff <= sync_s_ff;
      per_cnt_ff <= sync_edge ? 20'h0_0000 : per_cnt_ff + 20'h0_0001;
      if (sync_edge) begin
        period_ff <= per_cnt_ff + 20'h0_0001;
      end
    end
  end

  logic [15:0] cfg_ff [`NUM_CH][`NUM_CFG];
  logic [1:0][4:0] stat_ff;

  genvar c;
  genvar k;
  generate
    for (c = 0; c < `NUM_CH; c++) begin : g_ch
      // configuration words
      for (k = 0; k < `NUM_CFG; k++) begin : g_cfg
        // reset word fixed per entry and channel at elaboration,
        // so the asynchronous reset branch loads a true constant
        localparam logic [15:0] RST_VAL =
          (4'(k) == `IX_PHASE) ?
            ((c == 0) ? `RST_PHASE_CH0 : `RST_PHASE_CH1) :
          (4'(k) == `IX_GAIN_CAL) ?
            ((c == 0) ? `RST_GAIN_CH0 : `RST_GAIN_CH1) :
          (4'(k) == `IX_OFFS_CAL) ?
            ((c == 0) ? `RST_OFFS_CH0 : `RST_OFFS_CH1) :
          (4'(k) == `IX_VOV_FAULT) ? `RST_VOV_FAULT :
          (4'(k) == `IX_VOV_ACT) ? `RST_ACTION :
          (4'(k) == `IX_VUV_ACT) ? `RST_ACTION :
          (4'(k) == `IX_VOV_WARN) ? `RST_VOV_WARN :
          (4'(k) == `IX_VUV_WARN) ? `RST_VUV_WARN :
          (4'(k) == `IX_VUV_FAULT) ? `RST_VUV_FAULT :
          (4'(k) == `IX_OC_FAULT) ? `RST_OC_FAULT :
          (4'(k) == `IX_OC_WARN) ? `RST_OC_WARN :
          (4'(k) == `IX_UC_FAULT) ? `RST_UC_FAULT :
          (4'(k) == `IX_OT_FAULT) ? `RST_OT_FAULT :
          16'h0000;
        // write strobe for this entry of this channel
        wire hit = cfg_wr & ch_sel[c] & (cmd_ix == 4'(k));
        always_ff @(posedge clk_i or negedge rstn_i) begin
          if (!rstn_i) begin
            cfg_ff[c][k] <= RST_VAL;
          end else if (hit) begin
            cfg_ff[c][k] <= wr_word;
          end
        end
      end

      // effective limits, fault limits clamped, overtemperature warning threshold unclamped
      wire signed [31:0] peak_lim = clamp(l11_q4(cfg_ff[c][`IX_OC_FAULT]),
        `CUR_MIN_Q4, `PEAK_OC_MAX_Q4);
      wire signed [31:0] valley_lim = clamp(l11_q4(cfg_ff[c][`IX_UC_FAULT]),
        `VALLEY_UC_MIN_Q4, `CUR_MAX_Q4);
      wire signed [31:0] ot_lim = clamp(l11_q4(cfg_ff[c][`IX_OT_FAULT]),
        `OT_MIN_Q4, `OT_MAX_Q4);
      wire signed [31:0] ot_warn = l11_q4(ot_warn_thr_i[c]);
      wire signed [31:0] sample = 32'(signed'(cur_sample_i[c]));
      wire signed [31:0] temp = 32'(signed'(temp_i[c]));

      // fault conditions
      wire qual = cur_sample_valid_i[c] & blank_done_i[c];
      wire ov_cond = vout_i[c] > cfg_ff[c][`IX_VOV_FAULT];
      wire uv_cond = (vout_i[c] < cfg_ff[c][`IX_VUV_FAULT]) &
                     output_on_i[c] & ~ramping_i[c];
      wire oc_cond = (qual & (sample > peak_lim)) |
                     avg_oc_fault_i[c];
      wire uc_cond = (qual & (sample < valley_lim)) |
                     avg_uc_fault_i[c];
      logic ot_hold_ff;
      wire ot_cond = (temp > ot_lim) | (ot_hold_ff & ~(temp < ot_warn));
      wire [4:0] cond = {ot_cond, uc_cond, oc_cond, uv_cond, ov_cond};
      logic [4:0] cond_d_ff;
      wire [4:0] rise = cond & ~cond_d_ff;

      // power good from warning window
      wire pg_nxt = output_on_i[c] &
        ~(vout_i[c] > cfg_ff[c][`IX_VOV_WARN]) &
        ~(vout_i[c] < cfg_ff[c][`IX_VUV_WARN]);

      // response selection: overvoltage first, then undervoltage
      logic [7:0] act;
      always_comb begin
        if (rise[`FB_OV]) begin
          act = cfg_ff[c][`IX_VOV_ACT][7:0];
        end else if (rise[`FB_UV]) begin
          act = cfg_ff[c][`IX_VUV_ACT][7:0];
        end else begin
          act = other_fault_action_i[c];
        end
      end
      wire trig = |rise;
      wire retry = (act[`RETRY_MSB:`RETRY_LSB] == `RETRY_ALWAYS);
      wire [31:0] delay_cyc = 32'(act[`DELAY_MSB:0] + 4'h1) *
                              32'(RETRY_UNIT_CYC);

      rail_fault_pkg::resp_state_t st_ff;
      rail_fault_pkg::resp_state_t nxt_st;
      logic [31:0] wait_ff;
      logic [31:0] nxt_wait;
      always_comb begin
        nxt_st = st_ff;
        nxt_wait = wait_ff;
        case (st_ff)
          rail_fault_pkg::RESP_RUN: begin
            if (trig && output_on_i[c]) begin
              nxt_st = retry ? rail_fault_pkg::RESP_RETRY_WAIT
                             : rail_fault_pkg::RESP_HOLD_OFF;
              nxt_wait = delay_cyc;
            end
          end
          rail_fault_pkg::RESP_RETRY_WAIT: begin
            if (!output_on_i[c]) begin
              nxt_st = rail_fault_pkg::RESP_RUN;
            end else if (trig && !retry) begin
              nxt_st = rail_fault_pkg::RESP_HOLD_OFF;
            end else if (wait_ff <= 32'h0000_0001) begin
              nxt_st = rail_fault_pkg::RESP_RUN;
            end else begin
              nxt_wait = wait_ff - 32'h0000_0001;
            end
          end
          rail_fault_pkg::RESP_HOLD_OFF: begin
            if (!output_on_i[c]) begin
              nxt_st = rail_fault_pkg::RESP_RUN;
            end
          end
          default: nxt_st = rail_fault_pkg::RESP_HOLD_OFF;
        endcase
      end

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          st_ff <= rail_fault_pkg::RESP_RUN;
          wait_ff <= 32'h0000_0000;
          cond_d_ff <= 5'h00;
          ot_hold_ff <= 1'b0;
          stat_ff[c] <= 5'h00;
          pgood_o[c] <= 1'b0;
          output_off_o[c] <= 1'b0;
        end else begin
          st_ff <= nxt_st;
          wait_ff <= nxt_wait;
          cond_d_ff <= cond;
          ot_hold_ff <= ot_cond;
          // a persisting condition wins over the clear
          stat_ff[c] <= (clear_faults ? 5'h00 : stat_ff[c]) | cond;
          pgood_o[c] <= pg_nxt;
          output_off_o[c] <= (nxt_st != rail_fault_pkg::RESP_RUN);
        end
      end

      // phase pulses, second phase half a period later
      wire [3:0] pos = cfg_ff[c][`IX_PHASE][3:0];
      wire [23:0] prod = 24'(pos) * 24'(period_ff);
      wire [19:0] off0 = prod[23:4];
      wire [20:0] sum1 = 21'(off0) + 21'(period_ff[19:1]);
      wire [20:0] wrap1 = (sum1 >= 21'(period_ff)) ?
                          sum1 - 21'(period_ff) : sum1;
      wire run = (period_ff != 20'h0_0000);
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          phase_pulse_o[c] <= 2'b00;
        end else begin
          phase_pulse_o[c][0] <= run & (per_cnt_ff == off0);
          phase_pulse_o[c][1] <= run & (per_cnt_ff == wrap1[19:0]);
        end
      end
    end
  endgenerate

  // read answer one cycle after the command
  wire [15:0] rd_word = is_page ? {8'h00, page_ff} : cfg_ff[rd_ch][cmd_ix];
  wire unsup = ~(cmd_known | is_page | is_clear) |
               (cmd_write_i & is_page & ~page_ok);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 16'h0000;
      rsp_unsup_o <= 1'b0;
      fault_status_o <= 10'h000;
      alert_o <= 1'b0;
    end else begin
      rsp_valid_o <= cmd_valid_i;
      rsp_data_o <= (cmd_valid_i & ~cmd_write_i & ~unsup) ? rd_word
                                                          : 16'h0000;
      rsp_unsup_o <= cmd_valid_i & unsup;
      fault_status_o <= stat_ff;
      alert_o <= |stat_ff;
    end
  end

endmodule
`default_nettype wire

// ### src/rail_fault_params.svh
// constants for the rail fault, limit and response configuration block
`ifndef RAIL_FAULT_PARAMS_SVH
`define RAIL_FAULT_PARAMS_SVH

`define CLK_MHZ 100
`define RETRY_UNIT_MS 35
`define NUM_CH 2
`define NUM_CFG 13

// command codes
`define CMD_PAGE 8'h00
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_PHASE 8'h37
`define CMD_GAIN_CAL 8'h38
`define CMD_OFFS_CAL 8'h39
`define CMD_VOV_FAULT 8'h40
`define CMD_VOV_ACT 8'h41
`define CMD_VOV_WARN 8'h42
`define CMD_VUV_WARN 8'h43
`define CMD_VUV_FAULT 8'h44
`define CMD_VUV_ACT 8'h45
`define CMD_OC_FAULT 8'h46
`define CMD_OC_WARN 8'h4a
`define CMD_UC_FAULT 8'h4b
`define CMD_OT_FAULT 8'h4f

// storage indices
`define IX_PHASE 4'h0
`define IX_GAIN_CAL 4'h1
`define IX_OFFS_CAL 4'h2
`define IX_VOV_FAULT 4'h3
`define IX_VOV_ACT 4'h4
`define IX_VOV_WARN 4'h5
`define IX_VUV_WARN 4'h6
`define IX_VUV_FAULT 4'h7
`define IX_VUV_ACT 4'h8
`define IX_OC_FAULT 4'h9
`define IX_OC_WARN 4'ha
`define IX_UC_FAULT 4'hb
`define IX_OT_FAULT 4'hc

// page values
`define PAGE_CH0 8'h00
`define PAGE_CH1 8'h01
`define PAGE_BOTH 8'hff

// reset values
`define RST_PHASE_CH0 16'h0021
`define RST_PHASE_CH1 16'h0022
`define RST_GAIN_CH0 16'hb2c3
`define RST_GAIN_CH1 16'hb2d7
`define RST_OFFS_CH0 16'hb529
`define RST_OFFS_CH1 16'hbddc
`define RST_VOV_FAULT 16'hffff
`define RST_VOV_WARN 16'hffff
`define RST_VUV_WARN 16'h0000
`define RST_VUV_FAULT 16'h0000
`define RST_ACTION 16'h0080
`define RST_OC_FAULT 16'he320
`define RST_OC_WARN 16'h0000
`define RST_UC_FAULT 16'he4e0
`define RST_OT_FAULT 16'heb98

// fixed and writable parts
`define PHASE_FIXED 16'h0020
`define PHASE_MASK 16'h000f
`define ACTION_FIXED 16'h0080
`define ACTION_MASK 16'h003f
`define RETRY_LSB 3
`define RETRY_MSB 5
`define DELAY_MSB 2
`define RETRY_ALWAYS 3'h7

// limits in amps or degrees, sixteenths of a unit
`define Q4_SHIFT 4
`define PEAK_OC_MAX_Q4 32'sh0000_0320
`define VALLEY_UC_MIN_Q4 -32'sh0000_0320
`define CUR_MAX_Q4 32'sh0000_0640
`define CUR_MIN_Q4 -32'sh0000_0640
`define OT_MAX_Q4 32'sh0000_0af0
`define OT_MIN_Q4 32'sh0000_0000

// fault bit positions
`define FB_OV 0
`define FB_UV 1
`define FB_OC 2
`define FB_UC 3
`define FB_OT 4
`define NUM_FB 5

`endif

// ### src/rail_fault_pkg.sv
// types for the rail fault, limit and response configuration block
package rail_fault_pkg;
  typedef enum logic [1:0] {
    RESP_RUN,
    RESP_HOLD_OFF,
    RESP_RETRY_WAIT
  } resp_state_t;
  typedef logic [15:0] cfg_word_t;
endpackage
